// ### dv/arc_sar_model.sv
// behavioural analog converter core answering start pulses
`timescale 1ns/1ps
module arc_sar_model (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        start_in,
    input  wire logic [7:0]  delay_in,
    input  wire logic [11:0] value_in,
    output logic             done_out,
    output logic [11:0]      result_out
);
    int          count;
    logic [11:0] last;

    // result lines carry the inverse of the last value outside the done
    // cycle, so a store taken at the wrong edge shows up as a mismatch
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            count      <= 0;
            done_out   <= 1'b0;
            last       <= 12'h000;
            result_out <= 12'hFFF;
        end else begin
            done_out   <= 1'b0;
            result_out <= ~last;
            if (start_in) begin
                count <= int'(delay_in);
            end else if (count == 1) begin
                done_out   <= 1'b1;
                result_out <= value_in;
                last       <= value_in;
                count      <= 0;
            end else if (count > 1) begin
                count <= count - 1;
            end
        end
    end
endmodule // arc_sar_model

// ### dv/tb.sv
// self-checking bench for the converter mode and result control block
`timescale 1ns/1ps
module tb;
    import arc_pkg::*;
    logic              clock_in  = 1'b0;
    logic              rst_in    = 1'b1;
    logic [ADDR_W-1:0] addr      = '0;
    logic              rd        = 1'b0;
    logic              wr        = 1'b0;
    logic [31:0]       wdata     = '0;
    logic              timer_irq = 1'b0;
    logic              ev_in     = 1'b0;
    logic              stop_in   = 1'b0;
    logic [11:0]       value     = 12'h000;
    logic [7:0]        delay     = 8'h05;
    logic [31:0]       rdata;
    logic [11:0]       result;
    logic [1:0]        pos;
    logic              waitreq, done, start, eight, ce, neg, iss, irq, snz;
    int mismatches = 0, checked = 0, cyc = 0, starts = 0, dones = 0;
    int irqs = 0, start_cyc = 0, trig_cyc = 0, done_cyc = 0;
    localparam logic [19:0] rst_addr [8] = '{TRIG_MODE_IDX, REF_RES_IDX,
        RESULT_WORD_IDX, RESULT_UPPER_IDX, UPPER_LIMIT_IDX, LOWER_LIMIT_IDX,
        RUN_CTRL_IDX, 20'h00000};
    localparam logic [15:0] rst_val [8] = '{16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [7:0]  refs [3] = '{8'h00, 8'h60, 8'hA0};
    localparam logic [7:0]  rr_ref [7] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h08, 8'h08, 8'h09};
    localparam logic [11:0] rr_val [7] = '{12'h155, 12'h300, 12'h0F0,
        12'h20F, 12'h21F, 12'h180, 12'h3FC};
    localparam logic [15:0] rr_word [7] = '{16'h1550, 16'h1550, 16'h1550,
        16'h20F0, 16'h21F0, 16'h21F0, 16'h3F00};
    localparam int          rr_irq [7] = '{1, 0, 0, 1, 1, 0, 1};
    localparam logic [7:0]  hw_mode [3] = '{8'hA0, 8'hE1, 8'hE0};
    // wait mode adds the stabilization count to the one-cycle start path
    localparam int          hw_lat [3] = '{1, STAB_WAIT_CYC + 1,
        STAB_WAIT_CYC + 1};

    always #50 clock_in = ~clock_in;

    arc_mode_result_ctrl u_dut (
        .clock_in                  (clock_in),
        .rst_in                    (rst_in),
        .avs_address_in            (addr),
        .avs_read_in               (rd),
        .avs_write_in              (wr),
        .avs_byteenable_in         (4'hF),
        .avs_writedata_in          (wdata),
        .avs_readdata_out          (rdata),
        .avs_waitrequest_out       (waitreq),
        .timer_ch1_irq_in          (timer_irq),
        .event_link_unit_in        (ev_in),
        .stop_mode_in              (stop_in),
        .sar_done_in               (done),
        .sar_result_in             (result),
        .sar_start_out             (start),
        .sar_eight_bit_out         (eight),
        .comparator_enable_out     (ce),
        .pos_ref_select_out        (pos),
        .neg_ref_select_out        (neg),
        .internal_source_select_out(iss),
        .conversion_done_irq_out   (irq),
        .snooze_active_out         (snz)
    );

    arc_sar_model u_sar (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .start_in  (start),
        .delay_in  (delay),
        .value_in  (value),
        .done_out  (done),
        .result_out(result)
    );

    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (start) begin
            starts    <= starts + 1;
            start_cyc <= cyc;
        end
        if (done) begin
            dones    <= dones + 1;
            done_cyc <= cyc;
        end
        if (irq) irqs <= irqs + 1;
        if (timer_irq | ev_in) trig_cyc <= cyc;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic w, input logic [19:0] a,
                       input logic [7:0] d, output logic [15:0] q);
        @(posedge clock_in);
        addr  <= a;
        wdata <= {24'h000000, d};
        wr    <= w;
        rd    <= ~w;
        do @(posedge clock_in); while (waitreq !== 1'b0);
        q = rdata[15:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [19:0] a, input logic [7:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [19:0] a, input logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, a, 8'h00, q);
        cmp(q, e);
    endtask

    task automatic wait_done(input int n);
        int t0;
        t0 = dones;
        repeat (200) if (dones < t0 + n) @(posedge clock_in);
        repeat (3) @(posedge clock_in);
    endtask

    task automatic pulse(input logic ev);
        @(posedge clock_in);
        timer_irq <= ~ev;
        ev_in     <= ev;
        @(posedge clock_in);
        timer_irq <= 1'b0;
        ev_in     <= 1'b0;
    endtask

    task automatic sw_conv(input logic [11:0] v, input int exp_irq);
        int i0;
        value <= v;
        wreg(RUN_CTRL_IDX, 8'h02);
        repeat (20) @(posedge clock_in);
        i0 = irqs;
        wreg(RUN_CTRL_IDX, 8'h03);
        wait_done(1);
        cmp(16'(irqs - i0), 16'(exp_irq));
        rchk(RUN_CTRL_IDX, 16'h0002);
        wreg(RUN_CTRL_IDX, 8'h00);
    endtask

    task automatic hw_conv(input logic [7:0] mode, input logic ev,
                           input int lat);
        int s0;
        int i0;
        wreg(TRIG_MODE_IDX, mode);
        wreg(RUN_CTRL_IDX, 8'h03);
        repeat (20) @(posedge clock_in);
        s0 = starts;
        i0 = irqs;
        pulse(~ev);
        repeat (15) @(posedge clock_in);
        cmp(16'(starts - s0), 16'h0000);
        pulse(ev);
        repeat (lat + 1) @(posedge clock_in);
        cmp({15'h0000, snz}, {15'h0000, stop_in});
        wait_done(1);
        cmp(16'(start_cyc - trig_cyc), 16'(lat));
        cmp(16'(irqs - i0), 16'h0001);
        cmp({15'h0000, snz}, 16'h0000);
        wreg(RUN_CTRL_IDX, 8'h00);
    endtask

    initial begin
        int i0;
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) rchk(rst_addr[i], rst_val[i]);
        wreg(20'h00000, 8'h5A);
        rchk(20'h00000, 16'h0000);
        wreg(RESULT_WORD_IDX, 8'h5A);
        rchk(RESULT_WORD_IDX, 16'h0000);
        wreg(TRIG_MODE_IDX, 8'hFF);
        rchk(TRIG_MODE_IDX, {8'h00, TRIG_MODE_MASK});
        wreg(RUN_CTRL_IDX, 8'h82);
        @(posedge clock_in);
        cmp({14'h0000, iss, ce}, 16'h0003);
        wreg(TRIG_MODE_IDX, 8'h00);
        rchk(TRIG_MODE_IDX, {8'h00, TRIG_MODE_MASK});
        wreg(RUN_CTRL_IDX, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wreg(REF_RES_IDX, refs[i]);
            @(posedge clock_in);
            cmp({13'h0000, pos, neg}, {13'h0000, refs[i][7:5]});
        end
        wreg(REF_RES_IDX, 8'h00);
        repeat (10) @(posedge clock_in);
        $display("test registers finished");
        wreg(TRIG_MODE_IDX, 8'h20);
        for (int i = 0; i < 7; i++) begin
            delay <= 8'(3 + 4 * i);
            wreg(REF_RES_IDX, rr_ref[i]);
            wreg(LOWER_LIMIT_IDX, 8'h10);
            wreg(UPPER_LIMIT_IDX, 8'h20);
            sw_conv(rr_val[i], rr_irq[i]);
            rchk(RESULT_WORD_IDX, rr_word[i]);
            rchk(RESULT_UPPER_IDX, {8'h00, rr_word[i][15:8]});
        end
        cmp({15'h0000, eight}, 16'h0001);
        $display("test window finished");
        wreg(REF_RES_IDX, 8'h00);
        wreg(TRIG_MODE_IDX, 8'h00);
        value <= 12'h180;
        delay <= 8'h08;
        wreg(RUN_CTRL_IDX, 8'h02);
        repeat (20) @(posedge clock_in);
        i0 = irqs;
        wreg(RUN_CTRL_IDX, 8'h03);
        wait_done(2);
        cmp(16'(start_cyc - done_cyc), 16'h0001);
        wreg(RUN_CTRL_IDX, 8'h00);
        cmp(16'(irqs - i0), 16'h0002);
        $display("test sequential finished");
        for (int i = 0; i < 3; i++) begin
            if (i == 2) begin
                wreg(REF_RES_IDX, 8'h04);
                stop_in <= 1'b1;
            end
            hw_conv(hw_mode[i], i == 1, hw_lat[i]);
        end
        stop_in <= 1'b0;
        wreg(REF_RES_IDX, 8'h00);
        $display("test hardware triggers finished");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        summarize();
    end
endmodule // tb

// ### verilog/arc_mode_result_ctrl.sv
// converter mode control, sequencer and register slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module arc_mode_result_ctrl
    import arc_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [3:0]        avs_byteenable_in,
    input  wire logic [31:0]       avs_writedata_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire logic              timer_ch1_irq_in,
    input  wire logic              event_link_unit_in,
    input  wire logic              stop_mode_in,
    input  wire logic              sar_done_in,
    input  wire logic [RES_W-1:0]  sar_result_in,
    output logic                   sar_start_out,
    output logic                   sar_eight_bit_out,
    output logic                   comparator_enable_out,
    output logic [1:0]             pos_ref_select_out,
    output logic                   neg_ref_select_out,
    output logic                   internal_source_select_out,
    output logic                   conversion_done_irq_out,
    output logic                   snooze_active_out
);
    typedef struct packed {
        arc_seq_type           seq;
        logic [STAB_CNT_W-1:0] cnt;
        logic [7:0]            trig_mode;
        logic [7:0]            ref_res;
        logic [7:0]            upper;
        logic [7:0]            lower;
        logic [7:0]            run_ctrl;
        logic                  start;
        logic                  irq;
        logic                  snooze;
        logic                  ack;
        logic [15:0]           rdata;
    } arc_top_state_type;

    arc_top_state_type st;
    arc_top_state_type next_st;
    arc_result_if      res_if ();

    logic       bus_req;
    logic       wr_en;
    logic       locked;
    logic       active;
    logic       trig_hit;
    logic       conv_end;
    logic [1:0] trig_src;
    logic [15:0] rd_val;

    arc_range_store u_store (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .res      (res_if.store)
    );

    assign bus_req  = avs_read_in || avs_write_in;
    // a write lands only at the edge where waitrequest is low
    assign wr_en    = avs_write_in && st.ack && avs_byteenable_in[0];
    assign locked   = st.run_ctrl[RUN_BIT] || st.run_ctrl[CE_BIT];
    assign active   = st.run_ctrl[RUN_BIT] && st.run_ctrl[CE_BIT];
    assign trig_src = st.trig_mode[TRIG_SRC_LSB +: 2];
    assign trig_hit = (trig_src == TRIG_SRC_TIMER && timer_ch1_irq_in)
                   || (trig_src == TRIG_SRC_EVENT && event_link_unit_in);
    assign conv_end = (st.seq == SEQ_CONV) && active && sar_done_in;

    assign res_if.done      = conv_end;
    assign res_if.data      = sar_result_in;
    assign res_if.eight_bit = st.ref_res[RES_SEL_BIT];
    assign res_if.invert    = st.ref_res[RANGE_INV_BIT];
    assign res_if.upper     = st.upper;
    assign res_if.lower     = st.lower;

    always_comb begin
        case (avs_address_in)
            TRIG_MODE_IDX:    rd_val = {8'h00, st.trig_mode};
            REF_RES_IDX:      rd_val = {8'h00, st.ref_res};
            RESULT_WORD_IDX:  rd_val = res_if.word;
            RESULT_UPPER_IDX: rd_val = {8'h00, res_if.upper_byte};
            UPPER_LIMIT_IDX:  rd_val = {8'h00, st.upper};
            LOWER_LIMIT_IDX:  rd_val = {8'h00, st.lower};
            RUN_CTRL_IDX:     rd_val = {8'h00, st.run_ctrl};
            STATUS_IDX:       rd_val = {14'h0000, st.snooze,
                                        st.seq != SEQ_IDLE};
            default:          rd_val = 16'h0000;
        endcase
    end

    always_comb begin
        next_st       = st;
        next_st.start = 1'b0;
        next_st.irq   = 1'b0;
        // one wait state: read data is captured, then answered
        next_st.ack   = bus_req && !st.ack;
        if (bus_req && !st.ack) begin
            next_st.rdata = rd_val;
        end

        case (st.seq)
            SEQ_IDLE: begin
                if (active) begin
                    if (!st.trig_mode[TM_HI_BIT]) begin
                        next_st.start = 1'b1;
                        next_st.seq   = SEQ_CONV;
                    end else if (trig_hit) begin
                        // trigger during stop with snooze enabled wakes only the converter
                        next_st.snooze = st.ref_res[SNOOZE_EN_BIT]
                                      && stop_mode_in;
                        if (st.trig_mode[TM_LO_BIT]) begin
                            next_st.seq = SEQ_STAB;
                            next_st.cnt = STAB_LOAD;
                        end else begin
                            next_st.start = 1'b1;
                            next_st.seq   = SEQ_CONV;
                        end
                    end
                end
            end
            SEQ_STAB: begin
                if (!active) begin
                    next_st.seq    = SEQ_IDLE;
                    next_st.snooze = 1'b0;
                end else if (st.cnt == '0) begin
                    next_st.start = 1'b1;
                    next_st.seq   = SEQ_CONV;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            SEQ_CONV: begin
                if (!active) begin
                    // abort drops the pending result
                    next_st.seq    = SEQ_IDLE;
                    next_st.snooze = 1'b0;
                end else if (sar_done_in) begin
                    next_st.irq = res_if.accept;
                    if (!st.trig_mode[ONE_SHOT_BIT]) begin
                        // repeats skip start and stabilization time
                        next_st.start = 1'b1;
                    end else begin
                        next_st.seq    = SEQ_IDLE;
                        next_st.snooze = 1'b0;
                        if (!st.trig_mode[TM_HI_BIT]) begin
                            next_st.run_ctrl[RUN_BIT] = 1'b0;
                        end
                    end
                end
            end
            default: begin
                next_st.seq = SEQ_IDLE;
            end
        endcase

        // software writes last, so a set beats a hardware clear
        if (wr_en) begin
            case (avs_address_in)
                TRIG_MODE_IDX: begin
                    if (!locked) begin
                        next_st.trig_mode =
                            avs_writedata_in[7:0] & TRIG_MODE_MASK;
                    end
                end
                REF_RES_IDX: begin
                    if (!locked) begin
                        next_st.ref_res =
                            avs_writedata_in[7:0] & REF_RES_MASK;
                    end
                end
                UPPER_LIMIT_IDX: begin
                    if (!locked) begin
                        next_st.upper = avs_writedata_in[7:0];
                    end
                end
                LOWER_LIMIT_IDX: begin
                    if (!locked) begin
                        next_st.lower = avs_writedata_in[7:0];
                    end
                end
                RUN_CTRL_IDX: begin
                    next_st.run_ctrl =
                        avs_writedata_in[7:0] & RUN_CTRL_MASK;
                end
                default: begin
                    next_st.run_ctrl = next_st.run_ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st.seq       <= SEQ_IDLE;
            st.cnt       <= '0;
            st.trig_mode <= TRIG_MODE_RST;
            st.ref_res   <= REF_RES_RST;
            st.upper     <= UPPER_LIMIT_RST;
            st.lower     <= LOWER_LIMIT_RST;
            st.run_ctrl  <= RUN_CTRL_RST;
            st.start     <= 1'b0;
            st.irq       <= 1'b0;
            st.snooze    <= 1'b0;
            st.ack       <= 1'b0;
            st.rdata     <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    assign avs_waitrequest_out        = bus_req && !st.ack;
    assign avs_readdata_out           = {16'h0000, st.rdata};
    assign sar_start_out              = st.start;
    assign sar_eight_bit_out          = st.ref_res[RES_SEL_BIT];
    assign comparator_enable_out      = st.run_ctrl[CE_BIT];
    assign pos_ref_select_out         = st.ref_res[POS_REF_LSB +: 2];
    assign neg_ref_select_out         = st.ref_res[NEG_REF_BIT];
    assign internal_source_select_out = st.run_ctrl[ISS_BIT];
    assign conversion_done_irq_out    = st.irq;
    assign snooze_active_out          = st.snooze;

    AST_SW_START: assert property (@(posedge clock_in) disable iff (rst_in)
        st.seq == SEQ_IDLE && active && !st.trig_mode[TM_HI_BIT]
        |=> sar_start_out)
        else $error("software mode did not start a conversion");
    AST_NOWAIT_START: assert property (@(posedge clock_in) disable iff (rst_in)
        st.seq == SEQ_IDLE && active && st.trig_mode[7:6] == 2'h2
        && trig_hit |=> sar_start_out)
        else $error("no-wait trigger did not start at once");
    // ten stabilization cycles, then the start pulse one cycle later
    AST_WAIT_STAB: assert property (@(posedge clock_in) disable iff (rst_in)
        st.seq == SEQ_IDLE && active && st.trig_mode[7:6] == 2'h3
        && trig_hit ##1 active[*8] ##1 active[*2]
        |=> sar_start_out)
        else $error("wait mode start not after stabilization");
    AST_WAIT_NO_EARLY: assert property (@(posedge clock_in) disable iff (rst_in)
        st.seq == SEQ_IDLE && active && st.trig_mode[7:6] == 2'h3
        && trig_hit |=> !sar_start_out [*8])
        else $error("wait mode started before stabilization");
    AST_NO_TRIG_IDLE: assert property (@(posedge clock_in) disable iff (rst_in)
        st.seq == SEQ_IDLE && st.trig_mode[TM_HI_BIT] && !trig_hit
        |=> !sar_start_out)
        else $error("hardware mode started without its trigger");
    AST_ONE_SHOT_STOP: assert property (@(posedge clock_in) disable iff (rst_in)
        conv_end && st.trig_mode[ONE_SHOT_BIT]
        && !st.trig_mode[TM_HI_BIT]
        && !(wr_en && avs_address_in == RUN_CTRL_IDX)
        |=> !st.run_ctrl[RUN_BIT] && st.seq == SEQ_IDLE)
        else $error("one-shot conversion did not stop");
    AST_SEQ_RESTART: assert property (@(posedge clock_in) disable iff (rst_in)
        conv_end && !st.trig_mode[ONE_SHOT_BIT] |=> sar_start_out)
        else $error("sequential mode did not restart");
    AST_IRQ_CAUSE: assert property (@(posedge clock_in) disable iff (rst_in)
        conversion_done_irq_out |-> $past(conv_end && res_if.accept)
        && res_if.word[15:8] == $past(sar_result_in[11:4]))
        else $error("interrupt without accepted conversion");
    AST_SNOOZE: assert property (@(posedge clock_in) disable iff (rst_in)
        st.seq == SEQ_IDLE && active && st.trig_mode[TM_HI_BIT]
        && trig_hit && st.ref_res[SNOOZE_EN_BIT] && stop_mode_in
        |=> snooze_active_out)
        else $error("snooze not entered on stop trigger");
    AST_MODE_LOCK: assert property (@(posedge clock_in) disable iff (rst_in)
        locked |=> $stable(st.trig_mode) && $stable(st.ref_res))
        else $error("mode register changed while running");
endmodule // arc_mode_result_ctrl

// ### verilog/arc_pkg.sv
// constants and types for the converter mode and result control block
package arc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDR_W        = 20;
    localparam int RES_W         = 12;

    // word indices; byte address is four times the index
    localparam logic [19:0] TRIG_MODE_IDX    = 20'hFFF32;
    localparam logic [19:0] REF_RES_IDX      = 20'hF0010;
    localparam logic [19:0] RESULT_WORD_IDX  = 20'hFFF1E;
    localparam logic [19:0] RESULT_UPPER_IDX = 20'hFFF1F;
    localparam logic [19:0] UPPER_LIMIT_IDX  = 20'hFFF40;
    localparam logic [19:0] LOWER_LIMIT_IDX  = 20'hFFF41;
    localparam logic [19:0] RUN_CTRL_IDX     = 20'hFFF42;
    localparam logic [19:0] STATUS_IDX       = 20'hFFF43;

    localparam logic [7:0]  TRIG_MODE_RST    = 8'h00;
    localparam logic [7:0]  REF_RES_RST      = 8'h00;
    localparam logic [7:0]  UPPER_LIMIT_RST  = 8'hFF;
    localparam logic [7:0]  LOWER_LIMIT_RST  = 8'h00;
    localparam logic [7:0]  RUN_CTRL_RST     = 8'h00;
    localparam logic [11:0] RESULT_RST       = 12'h000;
    localparam logic [7:0]  TRIG_MODE_MASK   = 8'hE3;
    localparam logic [7:0]  REF_RES_MASK     = 8'hED;
    localparam logic [7:0]  RUN_CTRL_MASK    = 8'h83;

    localparam int TM_HI_BIT      = 7;
    localparam int TM_LO_BIT      = 6;
    localparam int ONE_SHOT_BIT   = 5;
    localparam int TRIG_SRC_LSB   = 0;
    localparam int POS_REF_LSB    = 6;
    localparam int NEG_REF_BIT    = 5;
    localparam int RANGE_INV_BIT  = 3;
    localparam int SNOOZE_EN_BIT  = 2;
    localparam int RES_SEL_BIT    = 0;
    localparam int RUN_BIT        = 0;
    localparam int CE_BIT         = 1;
    localparam int ISS_BIT        = 7;
    localparam int BUSY_BIT       = 0;
    localparam int SNOOZE_ACT_BIT = 1;

    localparam logic [1:0] TRIG_SRC_TIMER = 2'h0;
    localparam logic [1:0] TRIG_SRC_EVENT = 2'h1;

    // power stabilization wait in hardware wait mode
    localparam int STAB_WAIT_NS = 1000;
    localparam int STAB_WAIT_CYC =
        (STAB_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_CNT_W = 4;
    localparam logic [STAB_CNT_W-1:0] STAB_LOAD =
        STAB_CNT_W'(STAB_WAIT_CYC - 1);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_STAB,
        SEQ_CONV
    } arc_seq_type;
endpackage

// ### verilog/arc_range_store.sv
// window check and result registers
`timescale 1ns/1ps
module arc_range_store
    import arc_pkg::*;
(
    input  wire logic   clock_in,
    input  wire logic   rst_in,
    arc_result_if.store res
);
    typedef struct packed {
        logic [RES_W-1:0] result;
    } arc_store_state_type;

    arc_store_state_type st;
    arc_store_state_type next_st;

    function automatic logic arc_in_window(input logic [RES_W-1:0] d,
                                           input logic [7:0] lo,
                                           input logic [7:0] up);
        arc_in_window = (lo <= d[11:4]) && (d[11:4] <= up);
    endfunction

    assign res.accept = res.done && (res.invert
        ^ arc_in_window(res.data, res.lower, res.upper));

    always_comb begin
        next_st = st;
        if (res.accept) begin
            next_st.result = res.data;
            if (res.eight_bit) begin
                next_st.result[3:2] = 2'h0;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st.result <= RESULT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign res.word       = {st.result, 4'h0};
    assign res.upper_byte = st.result[11:4];

    AST_HOLD_ON_REJECT: assert property (@(posedge clock_in) disable iff (rst_in)
        !res.accept |=> $stable(res.word))
        else $error("result changed without acceptance");
    AST_INSIDE_ACCEPTED: assert property (@(posedge clock_in) disable iff (rst_in)
        res.done && !res.invert
        && arc_in_window(res.data, res.lower, res.upper) |-> res.accept)
        else $error("in-window result not accepted");
    AST_EIGHT_BIT_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
        res.accept && res.eight_bit |=> res.word[7:6] == 2'h0)
        else $error("8-bit result has bits 7:6 set");
    AST_UPPER_BYTE: assert property (@(posedge clock_in) disable iff (rst_in)
        res.accept |=> res.upper_byte == $past(res.data[11:4]))
        else $error("upper byte not result bits 11:4");
endmodule // arc_range_store

// ### verilog/arc_result_if.sv
// carrier between sequencer and result store
`timescale 1ns/1ps
interface arc_result_if;
    import arc_pkg::*;
    logic             done;
    logic [RES_W-1:0] data;
    logic             eight_bit;
    logic             invert;
    logic [7:0]       upper;
    logic [7:0]       lower;
    logic             accept;
    logic [15:0]      word;
    logic [7:0]       upper_byte;
    modport ctrl  (output done, data, eight_bit, invert, upper, lower,
                   input  accept, word, upper_byte);
    modport store (input  done, data, eight_bit, invert, upper, lower,
                   output accept, word, upper_byte);
endinterface
